//--- verilog/nipc_pkg.sv
// package for the nested interrupt priority controller
//
// Contract
// - four nesting levels, thirteen maskable vectors, reset and trap events.
// - vectors fixed between FFE0h and FFFFh in hardware priority order.
// - current level held in condition code bits 5 and 3.
// - entry waits for the current instruction to finish.
// - entry stacks program counter, index, accumulator and condition code.
// - entry loads level bits from the serviced vector's priority field.
// - after stacking, program counter loads the vector and fetch starts.
// - return pops saved registers including level bits, resuming old level.
// - level 0 encodes as 10, level 3 as 11.
// - highest software level wins, ties go to highest hardware priority.
// - hardware priorities unique, so arbitration yields exactly one winner.
// - unserviced requests stay latched pending until they become highest.
// - reset and trap ignore level bits, load vector, set level 3.
// - trap taken whenever executed; reset and trap end halt mode.
// - reset has top priority; reset and trap rank above all levels.
// - maskable request served only if enabled and level strictly higher.
// - edge external request latched, cleared when its handler is entered.
// - selected pins sharing one external line are ORed.
// - peripheral request only while its flag and enable are both set.
// - peripheral clear sequence resets the latch, dropping pending request.
// - all interrupts end wait (here only trap or a request eligible for service); halt exit served first by capable source.
// - concurrent mode never preempts; nested mode allows; no overflow flag.
// - two-bit level per vector, four per 8-bit register, reset all ones.
// - writing level 0 into a priority field is ignored for that field.
package nipc_pkg;

  localparam int NUM_VEC = 13;
  localparam int NUM_PINS = 6;
  localparam int NUM_EXT = 3;
  localparam int EXT_FIRST = 2;

  // register offsets
  localparam logic [3:0] OFF_PRIO0 = 4'h0;
  localparam logic [3:0] OFF_PRIO1 = 4'h1;
  localparam logic [3:0] OFF_PRIO2 = 4'h2;
  localparam logic [3:0] OFF_PRIO3 = 4'h3;
  localparam logic [3:0] OFF_CTRL = 4'h4;
  localparam logic [3:0] OFF_LEVEL = 4'h5;
  localparam logic [3:0] OFF_PEND_LO = 4'h6;
  localparam logic [3:0] OFF_PEND_HI = 4'h7;
  localparam logic [3:0] OFF_PIN_SEL = 4'h8;

  // field positions
  localparam int CC_BIT_HI = 5;
  localparam int CC_BIT_LO = 3;
  localparam int CTRL_NESTED = 0;

  // reset values and encodings
  localparam logic [25:0] PRIO_RST = 26'h3FFFFFF;
  localparam logic [5:0] PRIO3_FILL = 6'h3F;
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [5:0] PIN_SEL_RST = 6'h3F;
  localparam logic [1:0] LVL0 = 2'h2;
  localparam logic [1:0] LVL1 = 2'h1;
  localparam logic [1:0] LVL2 = 2'h0;
  localparam logic [1:0] LVL3 = 2'h3;

  // vector addresses
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP = 16'hFFFC;
  localparam logic [15:0] VEC_BASE = 16'hFFFA;

  // vectors able to end halt mode
  localparam logic [12:0] HALT_CAPABLE = 13'h041D;

  typedef enum logic [1:0] {
    NIPC_IDLE = 2'h0,
    NIPC_STACK = 2'h1,
    NIPC_LOAD = 2'h3,
    NIPC_BOOT = 2'h2
  } nipc_state_e;

  typedef struct packed {
    logic load;
    logic [15:0] vector;
    logic [1:0] level;
  } nipc_entry_s;

endpackage : nipc_pkg

//--- verilog/nipc_ctrl.sv
// nested interrupt priority controller with core entry sequencing
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module nipc_ctrl (
  input wire logic ref_clk,
  input wire logic srst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // peripheral sources
  input wire logic [12:0] periph_flag,
  input wire logic [12:0] periph_en,
  input wire logic [12:0] periph_clr,
  input wire logic [5:0] ext_pin,
  // core side
  input wire logic instr_end,
  input wire logic trap_exec,
  input wire logic stack_done,
  input wire logic return_from_handler,
  input wire logic [7:0] popped_cc,
  input wire logic cc_wr,
  input wire logic [7:0] cc_wdata,
  input wire logic halt_mode,
  input wire logic wait_mode,
  output logic stack_req,
  output nipc_pkg::nipc_entry_s entry,
  output logic [1:0] condition_code_reg,
  output logic exit_halt,
  output logic exit_wait
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // ascending priority order 10, 01, 00, 11
  function automatic logic [1:0] lvl_rank(input logic [1:0] enc);
    logic [1:0] r;
    r = 2'h0;
    unique case (enc)
      nipc_pkg::LVL0: r = 2'h0;
      nipc_pkg::LVL1: r = 2'h1;
      nipc_pkg::LVL2: r = 2'h2;
      nipc_pkg::LVL3: r = 2'h3;
    endcase
    return r;
  endfunction : lvl_rank

  // vectors descend two bytes per hardware priority step
  function automatic logic [15:0] vec_addr(input logic [3:0] idx);
    return nipc_pkg::VEC_BASE - {11'h000, idx, 1'b0};
  endfunction : vec_addr

  // programmed level of one maskable vector
  function automatic logic [1:0] field_lvl(input logic [25:0] p,
                                           input logic [3:0] v);
    return p[2*v +: 2];
  endfunction : field_lvl

  // priority register index and field slot name one vector
  function automatic logic [3:0] field_vec(input logic [1:0] reg_idx,
                                           input logic [1:0] slot);
    return {reg_idx, slot};
  endfunction : field_vec

  ////////////////////////////////////////////////////////////////////////////
  // state

  nipc_pkg::nipc_state_e state;
  logic [25:0] prio;
  logic [7:0] ctrl;
  logic [5:0] pin_sel;
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic [2:0] line_prev;
  logic [12:0] pend;
  logic trap_pend;
  logic [1:0] level;
  logic [3:0] depth;
  logic halt_woken;
  logic serve_trap;
  logic [3:0] serve_idx;
  logic [1:0] serve_lvl;

  logic [2:0] line_now;
  logic [12:0] req;
  logic [12:0] eligible;
  logic any_elig;
  logic [3:0] win_idx;
  logic win_valid;
  logic [1:0] win_rank;
  logic take;
  logic nested;

  assign nested = ctrl[nipc_pkg::CTRL_NESTED];

  ////////////////////////////////////////////////////////////////////////////
  // external pins: synchronise, OR per line, detect rising edges

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pin_meta <= 6'h00;
      pin_sync <= 6'h00;
    end else begin
      pin_meta <= ext_pin;
      pin_sync <= pin_meta;
    end
  end

  genvar g;
  generate
    for (g = 0; g < nipc_pkg::NUM_EXT; g++) begin : g_line
      // two pins share each external line
      assign line_now[g] = |(pin_sync[2*g +: 2] & pin_sel[2*g +: 2]);
    end
  endgenerate

  // pins idle low, so a cleared last level gives no false edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      line_prev <= 3'h0;
    end else begin
      line_prev <= line_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request latches

  always_comb begin
    req = periph_flag & periph_en;
    for (int i = 0; i < nipc_pkg::NUM_EXT; i++) begin
      req[nipc_pkg::EXT_FIRST + i] = line_now[i] & ~line_prev[i];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pend <= 13'h0000;
    end else begin
      for (int i = 0; i < nipc_pkg::NUM_VEC; i++) begin
        if (req[i]) begin
          pend[i] <= 1'b1;
        end else if (periph_clr[i]) begin
          pend[i] <= 1'b0;
        end else if (state == nipc_pkg::NIPC_LOAD && !serve_trap &&
                     serve_idx == 4'(i)) begin
          pend[i] <= 1'b0;
        end
      end
    end
  end

  // trap comes from the instruction stream, so nothing can clear it early
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      trap_pend <= 1'b0;
    end else if (trap_exec) begin
      trap_pend <= 1'b1;
    end else if (state == nipc_pkg::NIPC_LOAD && serve_trap) begin
      trap_pend <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbitration

  always_comb begin
    eligible = 13'h0000;
    for (int i = 0; i < nipc_pkg::NUM_VEC; i++) begin
      eligible[i] = pend[i] &&
        lvl_rank(field_lvl(prio, 4'(i))) > lvl_rank(level);
      // concurrent mode never preempts a running handler
      if (!nested && depth != 4'h0) begin
        eligible[i] = 1'b0;
      end
      // first service after halt must be a capable source
      if ((halt_mode || halt_woken) &&
          !nipc_pkg::HALT_CAPABLE[i]) begin
        eligible[i] = 1'b0;
      end
    end
  end

  assign any_elig = |eligible;

  always_comb begin
    win_idx = 4'h0;
    win_valid = 1'b0;
    win_rank = 2'h0;
    // walk from lowest hardware priority so ties settle on the lower index
    for (int i = nipc_pkg::NUM_VEC - 1; i >= 0; i--) begin
      if (eligible[i] && (!win_valid ||
          lvl_rank(field_lvl(prio, 4'(i))) >= win_rank)) begin
        win_idx = 4'(i);
        win_rank = lvl_rank(field_lvl(prio, 4'(i)));
        win_valid = 1'b1;
      end
    end
  end

  // trap ranks above every level; accepted only at an instruction boundary
  assign take = state == nipc_pkg::NIPC_IDLE && instr_end &&
                (trap_pend || win_valid);

  ////////////////////////////////////////////////////////////////////////////
  // entry sequence

  // boot loads the reset vector without stacking
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= nipc_pkg::NIPC_BOOT;
    end else begin
      unique case (state)
        nipc_pkg::NIPC_BOOT: state <= nipc_pkg::NIPC_IDLE;
        nipc_pkg::NIPC_IDLE: begin
          if (take) begin
            state <= nipc_pkg::NIPC_STACK;
          end
        end
        nipc_pkg::NIPC_STACK: begin
          if (stack_done) begin
            state <= nipc_pkg::NIPC_LOAD;
          end
        end
        nipc_pkg::NIPC_LOAD: state <= nipc_pkg::NIPC_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      serve_trap <= 1'b0;
      serve_idx <= 4'h0;
      serve_lvl <= nipc_pkg::LVL3;
    end else if (take) begin
      serve_trap <= trap_pend;
      serve_idx <= win_idx;
      serve_lvl <= trap_pend ? nipc_pkg::LVL3
                             : field_lvl(prio, win_idx);
    end
  end

  // keeps the capable-only filter until the first entry after halt
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      halt_woken <= 1'b0;
    end else if (halt_mode && (any_elig || trap_pend)) begin
      halt_woken <= 1'b1;
    end else if (state == nipc_pkg::NIPC_LOAD) begin
      halt_woken <= 1'b0;
    end
  end

  // nesting depth only steers concurrent mode; overflow is silent
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      depth <= 4'h0;
    end else if (state == nipc_pkg::NIPC_LOAD) begin
      if (depth != 4'hF) begin
        depth <= depth + 4'h1;
      end
    end else if (return_from_handler && depth != 4'h0) begin
      depth <= depth - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // current level bits

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      level <= nipc_pkg::LVL3;
    end else if (state == nipc_pkg::NIPC_LOAD) begin
      level <= serve_lvl;
    end else if (return_from_handler) begin
      level <= {popped_cc[nipc_pkg::CC_BIT_HI],
                popped_cc[nipc_pkg::CC_BIT_LO]};
    end else if (cc_wr) begin
      level <= {cc_wdata[nipc_pkg::CC_BIT_HI],
                cc_wdata[nipc_pkg::CC_BIT_LO]};
    end
  end

  assign condition_code_reg = level;

  ////////////////////////////////////////////////////////////////////////////
  // core outputs

  // vector and level hold between loads for the core to read
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      entry <= '0;
    end else begin
      entry.load <= 1'b0;
      if (state == nipc_pkg::NIPC_BOOT) begin
        entry.load <= 1'b1;
        entry.vector <= nipc_pkg::VEC_RESET;
        entry.level <= nipc_pkg::LVL3;
      end else if (state == nipc_pkg::NIPC_STACK && stack_done) begin
        entry.load <= 1'b1;
        entry.vector <= serve_trap ? nipc_pkg::VEC_TRAP
                                   : vec_addr(serve_idx);
        entry.level <= serve_lvl;
      end
    end
  end

  assign stack_req = state == nipc_pkg::NIPC_STACK;

  ////////////////////////////////////////////////////////////////////////////
  // low power exits

  assign exit_halt = halt_mode && (trap_pend || any_elig);
  assign exit_wait = wait_mode && (trap_pend || win_valid);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prio <= nipc_pkg::PRIO_RST;
    end else if (reg_wr && reg_addr <= nipc_pkg::OFF_PRIO3) begin
      for (int j = 0; j < 4; j++) begin
        if (reg_wdata[2*j +: 2] != nipc_pkg::LVL0 &&
            field_vec(reg_addr[1:0], 2'(j)) <
            4'(nipc_pkg::NUM_VEC)) begin
          prio[2*field_vec(reg_addr[1:0], 2'(j)) +: 2] <=
            reg_wdata[2*j +: 2];
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl <= nipc_pkg::CTRL_RST;
      pin_sel <= nipc_pkg::PIN_SEL_RST;
    end else if (reg_wr) begin
      if (reg_addr == nipc_pkg::OFF_CTRL) begin
        ctrl <= {7'h00, reg_wdata[nipc_pkg::CTRL_NESTED]};
      end
      if (reg_addr == nipc_pkg::OFF_PIN_SEL) begin
        pin_sel <= reg_wdata[5:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      // unmapped indexes and idle cycles read zero
      unique case (reg_addr)
        nipc_pkg::OFF_PRIO0: reg_rdata <= prio[7:0];
        nipc_pkg::OFF_PRIO1: reg_rdata <= prio[15:8];
        nipc_pkg::OFF_PRIO2: reg_rdata <= prio[23:16];
        nipc_pkg::OFF_PRIO3: reg_rdata <= {nipc_pkg::PRIO3_FILL, prio[25:24]};
        nipc_pkg::OFF_CTRL: reg_rdata <= ctrl;
        nipc_pkg::OFF_LEVEL: reg_rdata <= {2'h0, level[1], 1'b0,
                                           level[0], 3'h0};
        nipc_pkg::OFF_PEND_LO: reg_rdata <= pend[7:0];
        nipc_pkg::OFF_PEND_HI: reg_rdata <= {2'h0, trap_pend, pend[12:8]};
        nipc_pkg::OFF_PIN_SEL: reg_rdata <= {2'h0, pin_sel};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : nipc_ctrl

//--- tb/nipc_chk_sva.sv
// assertions on entry sequencing and level handling of the controller
`timescale 1ns/10ps
module nipc_chk (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic stack_req,
  input wire logic stack_done,
  input wire logic return_from_handler,
  input wire logic [7:0] popped_cc,
  input wire logic cc_wr,
  input wire logic [7:0] cc_wdata,
  input wire nipc_pkg::nipc_entry_s entry,
  input wire logic [1:0] condition_code_reg
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic [1:0] ret_lvl;
  logic [1:0] cc_lvl;
  // capture the handed level, it only stands with its strobe
  always_ff @(posedge ref_clk) begin
    ret_lvl <= {popped_cc[5], popped_cc[3]};
    cc_lvl <= {cc_wdata[5], cc_wdata[3]};
  end
  boot_entry_a: assert property ($fell(srst) |-> ##[1:2]
    entry.load && entry.vector == 16'hFFFE && entry.level == 2'h3)
    else $error("boot entry wrong");
  stack_hold_a: assert property (
    stack_req && !stack_done |=> stack_req) else $error("stack dropped");
  load_after_a: assert property (
    stack_req && stack_done |=> entry.load && !stack_req)
    else $error("no vector load");
  load_pulse_a: assert property (
    entry.load |=> !entry.load) else $error("load too long");
  entry_level_a: assert property (
    entry.load |=> condition_code_reg == entry.level)
    else $error("level not loaded");
  ret_level_a: assert property (
    return_from_handler && !entry.load |=> condition_code_reg == ret_lvl)
    else $error("level not restored");
  cc_write_a: assert property (
    cc_wr && !return_from_handler && !entry.load
    |=> condition_code_reg == cc_lvl) else $error("level write lost");
  vec_range_a: assert property (
    entry.load |-> entry.vector >= 16'hFFE0 && !entry.vector[0])
    else $error("vector out of range");
  nmi_level_a: assert property (
    entry.load && entry.vector >= 16'hFFFC |-> entry.level == 2'h3)
    else $error("event level wrong");
  no_lvl0_a: assert property (
    entry.load |-> entry.level != 2'h2) else $error("level 0 served");
endmodule : nipc_chk
bind nipc_ctrl nipc_chk i_nipc_chk (.*);

//--- tb/nipc_core_model.sv
// core stand-in: instruction boundaries and the stacking handshake
`timescale 1ns/10ps
module nipc_core_model (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic stack_req,
  output logic instr_end,
  output logic stack_done
);
  logic [1:0] phase;
  logic [2:0] wait_cnt;
  logic slow;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      phase <= 2'h0;
      wait_cnt <= 3'h0;
      slow <= 1'b0;
      instr_end <= 1'b0;
      stack_done <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      // sparse boundaries so a take really waits for one
      instr_end <= phase == 2'h3;
      stack_done <= 1'b0;
      if (stack_req && !stack_done) begin
        wait_cnt <= wait_cnt + 3'h1;
        // alternate a prompt push and a five-cycle push
        if (wait_cnt == (slow ? 3'h4 : 3'h0)) begin
          stack_done <= 1'b1;
          wait_cnt <= 3'h0;
          slow <= !slow;
        end
      end
    end
  end
endmodule : nipc_core_model

//--- tb/tb.sv
// self-checking bench for the interrupt priority controller
`timescale 1ns/10ps
module tb;
  logic ref_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic trap_exec = 1'b0, return_from_handler = 1'b0, cc_wr = 1'b0;
  logic halt_mode = 1'b0, wait_mode = 1'b0;
  logic instr_end, stack_done, stack_req, exit_halt, exit_wait;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, popped_cc = 8'h00, cc_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [12:0] periph_flag = 13'h0000, periph_en = 13'h0000;
  logic [12:0] periph_clr = 13'h0000;
  logic [5:0] ext_pin = 6'h00;
  logic [1:0] condition_code_reg;
  nipc_pkg::nipc_entry_s entry;
  int failures = 0, n_tests = 0, seed = 76;
  logic [7:0] prio [4] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [15:0] vq [$];
  logic [1:0] lq [$];

  always #12.5 ref_clk = ~ref_clk;
  nipc_ctrl i_nipc_ctrl (.*);
  nipc_core_model i_nipc_core_model (.*);

  always @(posedge ref_clk) begin
    if (entry.load === 1'b1) begin
      vq.push_back(entry.vector);
      lq.push_back(entry.level);
    end
  end

  function automatic logic [1:0] lv(input int i);
    return prio[i / 4][2 * (i % 4) +: 2];
  endfunction : lv
  function automatic int rank(input logic [1:0] l);
    return l == 2'h2 ? 0 : l == 2'h1 ? 1 : l == 2'h0 ? 2 : 3;
  endfunction : rank
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // read data stand only in the cycle after the strobe
    @(posedge ref_clk);
    q = reg_rdata;
  endtask : bus
  task automatic expect_entry(input logic [15:0] v, input logic [1:0] l);
    repeat (100) if (vq.size() == 0) @(posedge ref_clk);
    chk(vq.size(), 1);
    if (vq.size() != 0) begin
      chk(vq.pop_front(), v);
      chk(lq.pop_front(), l);
    end
  endtask : expect_entry
  // flag drops first: a set would win over the clear
  task automatic leave(input int i);
    if (i >= 0)
      periph_flag[i] <= 1'b0;
    repeat (2) @(posedge ref_clk);
    if (i >= 0)
      periph_clr[i] <= 1'b1;
    popped_cc <= 8'h20;
    return_from_handler <= 1'b1;
    @(posedge ref_clk);
    periph_clr <= 13'h0000;
    return_from_handler <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(condition_code_reg, 2'h2);
  endtask : leave
  task automatic close_out;
    $display("%0d checks, %0d mismatches", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    close_out();
  end
  initial begin
    logic [7:0] d;
    logic [7:0] q;
    int best;
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    expect_entry(16'hFFFE, 2'h3);
    $display("boot test done");
    for (int r = 0; r < 6; r++) begin
      bus(1'b0, r == 5 ? 4'hF : 4'(r), 8'h00, q);
      chk(q, r < 4 ? 8'hFF : r == 4 ? 8'h01 : 8'h00);
    end
    for (int r = 0; r < 4; r++) begin
      d = r == 1 ? 8'h64 : 8'($random(seed));
      bus(1'b1, 4'(r), d, q);
      for (int k = 0; k < 8; k += 2)
        if (d[k +: 2] != 2'h2 && (r < 3 || k == 0))
          prio[r][k +: 2] = d[k +: 2];
      bus(1'b0, 4'(r), 8'h00, q);
      chk(q, prio[r]);
    end
    $display("register test done");
    cc_wdata <= 8'h20;
    cc_wr <= 1'b1;
    @(posedge ref_clk);
    cc_wr <= 1'b0;
    bus(1'b0, 4'h5, 8'h00, q);
    chk(q, 8'h20);
    cc_wdata <= 8'h28;
    cc_wr <= 1'b1;
    @(posedge ref_clk);
    cc_wr <= 1'b0;
    periph_en <= 13'($random(seed)) | 13'h0003;
    periph_flag <= 13'h1FFF;
    wait_mode <= 1'b1;
    repeat (30) @(posedge ref_clk);
    chk(vq.size(), 0);
    chk(exit_wait, 1'b0);
    trap_exec <= 1'b1;
    @(posedge ref_clk);
    trap_exec <= 1'b0;
    @(posedge ref_clk);
    chk(exit_wait, 1'b1);
    wait_mode <= 1'b0;
    expect_entry(16'hFFFC, 2'h3);
    leave(-1);
    $display("mask and trap test done");
    for (int n = 0; n < 13; n++) begin
      best = -1;
      for (int i = 0; i < 13; i++)
        // vectors 2 to 4 follow the external lines, not the flags
        if (periph_flag[i] && periph_en[i] && (i < 2 || i > 4) &&
            (best < 0 || rank(lv(i)) > rank(lv(best))))
          best = i;
      if (best >= 0) begin
        expect_entry(16'hFFFA - 16'(2 * best), lv(best));
        leave(best);
      end
    end
    repeat (30) @(posedge ref_clk);
    chk(vq.size(), 0);
    $display("arbitration test done");
    bus(1'b1, 4'h0, 8'hFF, q);
    prio[0] = 8'hFF;
    halt_mode <= 1'b1;
    periph_flag[1] <= 1'b1;
    repeat (20) @(posedge ref_clk);
    chk(exit_halt, 1'b0);
    chk(vq.size(), 0);
    bus(1'b0, 4'h6, 8'h00, q);
    chk(q, 8'h02);
    ext_pin <= 6'h02;
    repeat (6) @(posedge ref_clk);
    chk(exit_halt, 1'b1);
    halt_mode <= 1'b0;
    ext_pin <= 6'h00;
    expect_entry(16'hFFF6, lv(2));
    leave(-1);
    expect_entry(16'hFFF8, lv(1));
    leave(1);
    repeat (30) @(posedge ref_clk);
    chk(vq.size(), 0);
    $display("halt test done");
    close_out();
  end
endmodule : tb
